// File: design/lcs_charger.sv
// Purpose: Charge phase sequencer, power path switches and event flags.
// Assumes: Comparator inputs are synchronous to hclk; AHB-Lite slave, zero wait.
// Notes: Analog selects leave as register fields; the loops live outside.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module lcs_charger #(
   parameter int MS_CYCLES_P = lcs_pkg::MS_CYCLES,
   parameter int S_MS_P = lcs_pkg::S_MS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic input_valid_cmp,
   input wire logic input_ovp_cmp,
   input wire logic vpwr_below_vbat_cmp,
   input wire logic batt_above_trkl_cmp,
   input wire logic batt_above_float_cmp,
   input wire logic batt_ovp_cmp,
   input wire logic batt_above_rchg_cmp,
   input wire logic chg_below_eoc_cmp,
   input wire logic input_limit_cmp,
   input wire logic temp_fault_cmp,
   output logic charger_buck_en,
   output logic input_protect_switch,
   output logic reverse_block_switch,
   output logic charge_pass_switch,
   output logic bypass_switch,
   output logic trickle_source_en,
   output logic cc_loop_en,
   output logic cv_loop_en,
   output logic [2:0] cc_current_sel,
   output logic [3:0] float_voltage_sel,
   output logic [1:0] overvoltage_margin_sel,
   output logic [2:0] eoc_current_sel,
   output logic [1:0] trickle_current_sel,
   output logic [1:0] input_limit_sel,
   output logic [3:0] charger_state_code
);
   import lcs_pkg::*;

   localparam int MCW = $clog2(MS_CYCLES_P);
   localparam int SCW = $clog2(S_MS_P);

   // Bus and register state
   logic dp_wr_reg, dp_wr_next;
   logic [7:0] dp_addr_reg, dp_addr_next;
   logic [31:0] rd_reg, rd_next;
   logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic [CFG_W-1:0] cfg_reg, cfg_next;
   logic [EV_W-1:0] ev_reg, ev_next, ev_set;
   logic kick;
   // Tick dividers
   logic [MCW-1:0] ms_cnt_reg, ms_cnt_next;
   logic [SCW-1:0] s_cnt_reg, s_cnt_next;
   logic ms_tick, s_tick;
   // Sequencer state
   lcs_state_type st_reg, st_next;
   logic [TMR_W-1:0] tmr_reg, tmr_next, tmr_full, tmr_lim;
   logic [TMR_W-1:0] wdt_reg, wdt_next;
   logic wdt_exp_reg, wdt_exp_next;
   logic [5:0] prev_reg, prev_next;
   logic trkl_ok, eoc_low, eoc_ok, fault_now, run_ok, start_ok, charging;
   logic buck_next, protect_next, pass_next, byp_next;
   logic [3:0] code_next;

   // Analog selects straight from the configuration flops
   assign cc_current_sel = cfg_reg[CF_CC +: 3];
   assign float_voltage_sel = cfg_reg[CF_FLOAT +: 4];
   assign overvoltage_margin_sel = cfg_reg[CF_OVM +: 2];
   assign eoc_current_sel = cfg_reg[CF_EOC +: 3];
   assign trickle_current_sel = cfg_reg[CF_TRKL +: 2];
   assign input_limit_sel = cfg_reg[CF_ILIM +: 2];
   assign hrdata = rd_reg;

   // Millisecond and second enables
   assign ms_tick = (ms_cnt_reg == MCW'(MS_CYCLES_P - 1));
   assign s_tick = ms_tick && (s_cnt_reg == SCW'(S_MS_P - 1));
   always_comb begin
      ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
      s_cnt_next = s_cnt_reg;
      if (s_tick) begin
         s_cnt_next = '0;
      end else if (ms_tick) begin
         s_cnt_next = s_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_cnt_reg <= '0;
         s_cnt_reg <= '0;
      end else begin
         ms_cnt_reg <= ms_cnt_next;
         s_cnt_reg <= s_cnt_next;
      end
   end

   // Comparator filters
   lcs_debounce #(.LIMIT(TRKL_FILT_TICKS)) u_trkl_filt (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(ms_tick),
      .raw(batt_above_trkl_cmp),
      .level(trkl_ok)
   );
   lcs_debounce #(.LIMIT(EOC_FILT_TICKS)) u_eoc_filt (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(ms_tick),
      .raw(chg_below_eoc_cmp),
      .level(eoc_low)
   );

   // AHB-Lite slave: read data prepared in the address phase, writes in data phase
   always_comb begin
      dp_wr_next = 1'b0;
      dp_addr_next = dp_addr_reg;
      rd_next = 32'h00000000;
      if (hsel && htrans[1] && hready) begin
         dp_wr_next = hwrite;
         dp_addr_next = haddr[7:0];
         if (!hwrite) begin
            case (haddr[7:0])
               OFS_CTRL: rd_next = 32'(ctrl_reg);
               OFS_CFG: rd_next = 32'(cfg_reg);
               OFS_STATUS: rd_next = 32'({input_valid_cmp, input_ovp_cmp, trkl_ok,
                  batt_ovp_cmp, temp_fault_cmp, eoc_low, input_limit_cmp,
                  wdt_exp_reg}) << SR_LEVELS | 32'(charger_state_code);
               OFS_EVENT: rd_next = 32'(ev_reg);
               default: rd_next = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         rd_reg <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_wr_reg <= dp_wr_next;
         dp_addr_reg <= dp_addr_next;
         rd_reg <= rd_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Software registers; a hardware event wins over a clear in the same cycle
   always_comb begin
      ctrl_next = ctrl_reg;
      cfg_next = cfg_reg;
      kick = 1'b0;
      ev_next = ev_reg | ev_set;
      if (dp_wr_reg) begin
         unique case (dp_addr_reg)
            OFS_CTRL: ctrl_next = hwdata[CTRL_W-1:0];
            OFS_CFG: cfg_next = hwdata[CFG_W-1:0];
            OFS_EVENT: ev_next = (ev_reg & ~hwdata[EV_W-1:0]) | ev_set;
            OFS_KICK: kick = 1'b1;
            default: kick = 1'b0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         cfg_reg <= CFG_RESET;
         ev_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         cfg_reg <= cfg_next;
         ev_reg <= ev_next;
      end
   end

   // Qualifiers for the sequencer
   assign charging = (st_reg == ST_TRKL) || (st_reg == ST_CC) || (st_reg == ST_CV);
   assign fault_now = batt_ovp_cmp || temp_fault_cmp || wdt_exp_reg;
   assign run_ok = input_valid_cmp && !ctrl_reg[CT_DISABLE];
   assign start_ok = run_ok && !fault_now;
   assign eoc_ok = batt_above_rchg_cmp && eoc_low;
   assign tmr_full = lcs_timer_limit(cfg_reg[CF_TMR +: 2]);

   // Charge phase sequencing, charge timer and watchdog
   always_comb begin
      st_next = st_reg;
      tmr_lim = tmr_full;
      if ((st_reg == ST_TRKL) && !ctrl_reg[CT_FORCE_TRKL]) begin
         tmr_lim = tmr_full >> 2;
      end
      if (input_ovp_cmp) begin
         st_next = ST_INOVP;
      end else if (charging && fault_now) begin
         st_next = ST_FAULT;
      end else if (charging && !run_ok) begin
         st_next = ST_IDLE;
      end else if (charging && (tmr_reg >= tmr_lim)) begin
         st_next = ST_TOUT;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
               if (start_ok) begin
                  st_next = (ctrl_reg[CT_FORCE_TRKL] || !trkl_ok) ? ST_TRKL : ST_CC;
               end
            end
            ST_TRKL: begin
               if (ctrl_reg[CT_FORCE_TRKL]) begin
                  if (batt_above_float_cmp) begin
                     st_next = ST_DONE;
                  end
               end else if (trkl_ok) begin
                  st_next = ST_CC;
               end
            end
            ST_CC: begin
               if (batt_above_float_cmp) begin
                  st_next = ST_CV;
               end
            end
            ST_CV: begin
               if (eoc_ok) begin
                  st_next = ST_DONE;
               end
            end
            ST_INOVP: st_next = ST_IDLE;
            ST_DONE, ST_TOUT, ST_FAULT: begin
               if (!run_ok) begin
                  st_next = ST_IDLE;
               end
            end
            default: st_next = ST_IDLE;
         endcase
      end
      // Timer restarts on entry to trickle or quick charge
      tmr_next = tmr_reg;
      if ((st_next != st_reg) && ((st_next == ST_TRKL) || (st_next == ST_CC))) begin
         tmr_next = '0;
      end else if (charging && s_tick && (tmr_reg != '1)) begin
         tmr_next = tmr_reg + 1'b1;
      end
      // Watchdog counts seconds while enabled; a write to the kick register restarts it
      wdt_next = wdt_reg;
      wdt_exp_next = wdt_exp_reg;
      if (!ctrl_reg[CT_WDOG_EN] || kick) begin
         wdt_next = '0;
         wdt_exp_next = 1'b0;
      end else if (wdt_reg >= lcs_wdog_limit(cfg_reg[CF_WDT +: 2])) begin
         wdt_exp_next = 1'b1;
      end else if (s_tick) begin
         wdt_next = wdt_reg + 1'b1;
      end
   end

   // Switch drives and state code, registered alongside the state
   always_comb begin
      protect_next = input_valid_cmp && !input_ovp_cmp;
      buck_next = protect_next && !batt_ovp_cmp;
      pass_next = !ctrl_reg[CT_ISOLATE];
      byp_next = ctrl_reg[CT_BYPASS] && vpwr_below_vbat_cmp && !ctrl_reg[CT_ISOLATE];
      unique case (st_next)
         ST_IDLE: code_next = CODE_IDLE;
         ST_TRKL: code_next = CODE_TRKL;
         ST_CC: code_next = CODE_CC;
         ST_CV: code_next = CODE_CV;
         ST_DONE: code_next = CODE_DONE;
         ST_TOUT: code_next = CODE_TOUT;
         ST_FAULT: code_next = CODE_FAULT;
         ST_INOVP: code_next = CODE_INOVP;
         default: code_next = CODE_IDLE;
      endcase
   end

   // Events from level rises and phase changes
   always_comb begin
      prev_next = {input_valid_cmp, input_ovp_cmp, trkl_ok, batt_ovp_cmp,
         temp_fault_cmp, input_limit_cmp};
      ev_set = '0;
      ev_set[EV_INDET] = input_valid_cmp && !prev_reg[5];
      ev_set[EV_INOVP] = input_ovp_cmp && !prev_reg[4];
      ev_set[EV_BATTERY_DETECT_EVENT] = trkl_ok && !prev_reg[3];
      ev_set[EV_BATTERY_OVERVOLTAGE_EVENT] = batt_ovp_cmp && !prev_reg[2];
      ev_set[EV_TEMP] = temp_fault_cmp && !prev_reg[1];
      ev_set[EV_ILIM] = charging && input_limit_cmp && !prev_reg[0];
      ev_set[EV_COMP] = (st_next == ST_DONE) && (st_reg != ST_DONE);
      ev_set[EV_TOUT] = (st_next == ST_TOUT) && (st_reg != ST_TOUT);
      ev_set[EV_WDOG] = wdt_exp_next && !wdt_exp_reg;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= ST_IDLE;
         tmr_reg <= '0;
         wdt_reg <= '0;
         wdt_exp_reg <= 1'b0;
         prev_reg <= '0;
         charger_buck_en <= 1'b0;
         input_protect_switch <= 1'b0;
         reverse_block_switch <= 1'b0;
         charge_pass_switch <= 1'b0;
         bypass_switch <= 1'b0;
         trickle_source_en <= 1'b0;
         cc_loop_en <= 1'b0;
         cv_loop_en <= 1'b0;
         charger_state_code <= CODE_IDLE;
      end else begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
         wdt_reg <= wdt_next;
         wdt_exp_reg <= wdt_exp_next;
         prev_reg <= prev_next;
         charger_buck_en <= buck_next;
         input_protect_switch <= protect_next;
         reverse_block_switch <= buck_next;
         charge_pass_switch <= pass_next;
         bypass_switch <= byp_next;
         trickle_source_en <= (st_next == ST_TRKL);
         cc_loop_en <= (st_next == ST_CC) || (st_next == ST_CV);
         cv_loop_en <= (st_next == ST_CV);
         charger_state_code <= code_next;
      end
   end

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_enter_trkl;
      (st_reg != ST_TRKL) ##1 (st_reg == ST_TRKL);
   endsequence
   sequence s_enter_done;
      (st_reg == ST_CV) ##1 (st_reg == ST_DONE);
   endsequence

   a_bypass_off: assert property (!ctrl_reg[CT_BYPASS] |=> !bypass_switch)
      else $error("bypass switch on without request");
   a_in_ovp: assert property (input_ovp_cmp |=> (charger_state_code == CODE_INOVP)
      && !charger_buck_en && !input_protect_switch && ev_reg[EV_INOVP])
      else $error("input over voltage not handled");
   a_rev_block: assert property (!charger_buck_en |-> !reverse_block_switch)
      else $error("reverse block on while buck off");
   a_iso_open: assert property (ctrl_reg[CT_ISOLATE] |=> !charge_pass_switch && !bypass_switch)
      else $error("isolate did not open switches");
   a_no_start: assert property ((st_reg == ST_IDLE) && !start_ok
      |=> (st_reg == ST_IDLE) || (st_reg == ST_INOVP))
      else $error("charge started while not allowed");
   a_in_detect: assert property ($rose(input_valid_cmp) |=> ev_reg[EV_INDET])
      else $error("input detect event missing");
   a_eoc_event: assert property (s_enter_done |-> ev_reg[EV_COMP] && $past(eoc_ok))
      else $error("charge complete event missing");
   a_trkl_timer: assert property (s_enter_trkl |-> (tmr_reg == '0) && trickle_source_en)
      else $error("timer not cleared on trickle entry");
   a_trkl_tout: assert property ((st_reg == ST_TRKL) && !ctrl_reg[CT_FORCE_TRKL]
      && !input_ovp_cmp && !fault_now && run_ok && (tmr_reg >= (tmr_full >> 2))
      |=> (st_reg == ST_TOUT) && (charger_state_code == CODE_TOUT))
      else $error("trickle timeout not taken");
   a_batt_ovp: assert property (batt_ovp_cmp |=> !charger_buck_en ##0 ev_reg[EV_BATTERY_OVERVOLTAGE_EVENT])
      else $error("battery over voltage not handled");
   a_temp_stop: assert property (charging && temp_fault_cmp && !input_ovp_cmp
      |=> (st_reg == ST_FAULT) && ev_reg[EV_TEMP] && !cc_loop_en)
      else $error("temperature fault did not stop charge");
endmodule

// File: design/lcs_debounce.sv
// Purpose: Level filter that passes a comparator change only after it holds.
// Assumes: tick is a one-cycle pulse per millisecond.
// Notes: Any return of raw to the filtered level restarts the count.
`timescale 1ns/10ps
module lcs_debounce #(
   parameter int LIMIT = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic raw,
   output logic level
);
   localparam int CW = $clog2(LIMIT + 1);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic lvl_reg;
   logic lvl_next;

   assign level = lvl_reg;

   // Count ticks while raw differs from the filtered level
   always_comb begin
      cnt_next = cnt_reg;
      lvl_next = lvl_reg;
      if (raw == lvl_reg) begin
         cnt_next = '0;
      end else if (tick) begin
         if (cnt_reg == CW'(LIMIT - 1)) begin
            lvl_next = raw;
            cnt_next = '0;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   // Filter state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= '0;
         lvl_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         lvl_reg <= lvl_next;
      end
   end
endmodule

// File: design/lcs_pkg.sv
// Purpose: Shared constants and types for the lithium cell charge sequencer.
// Assumes: 40 MHz hclk; register offsets are byte addresses on a 32-bit AHB-Lite bus.
// Notes: Limits of the charge timer and watchdog are counted in seconds.
package lcs_pkg;
   // Clock and tick timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int S_MS = 1000;
   localparam int TRKL_FILT_MS = 32;
   localparam int EOC_FILT_MS = 1;
   // One extra tick so a filter never settles early, whatever the divider phase
   localparam int TRKL_FILT_TICKS = TRKL_FILT_MS + 1;
   localparam int EOC_FILT_TICKS = EOC_FILT_MS + 1;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_EVENT = 8'h0C;
   localparam logic [7:0] OFS_KICK = 8'h10;

   // Control register bits
   localparam int CT_DISABLE = 0;
   localparam int CT_FORCE_TRKL = 1;
   localparam int CT_BYPASS = 2;
   localparam int CT_ISOLATE = 3;
   localparam int CT_WDOG_EN = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

   // Configuration register field positions
   localparam int CF_CC = 0;
   localparam int CF_FLOAT = 3;
   localparam int CF_OVM = 7;
   localparam int CF_EOC = 9;
   localparam int CF_TRKL = 12;
   localparam int CF_ILIM = 14;
   localparam int CF_TMR = 16;
   localparam int CF_WDT = 18;
   localparam int CFG_W = 20;
   localparam logic [CFG_W-1:0] CFG_RESET = 20'h00000;

   // Status register field positions
   localparam int SR_LEVELS = 8;

   // Sticky event bits
   localparam int EV_INDET = 0;
   localparam int EV_INOVP = 1;
   localparam int EV_BATTERY_DETECT_EVENT = 2;
   localparam int EV_BATTERY_OVERVOLTAGE_EVENT = 3;
   localparam int EV_TEMP = 4;
   localparam int EV_COMP = 5;
   localparam int EV_ILIM = 6;
   localparam int EV_TOUT = 7;
   localparam int EV_WDOG = 8;
   localparam int EV_W = 9;

   // Charger state codes seen by software
   localparam logic [3:0] CODE_IDLE = 4'h0;
   localparam logic [3:0] CODE_INOVP = 4'h2;
   localparam logic [3:0] CODE_TRKL = 4'h8;
   localparam logic [3:0] CODE_CC = 4'h9;
   localparam logic [3:0] CODE_CV = 4'hA;
   localparam logic [3:0] CODE_DONE = 4'hB;
   localparam logic [3:0] CODE_TOUT = 4'hC;
   localparam logic [3:0] CODE_FAULT = 4'hD;

   localparam int TMR_W = 16;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_TRKL = 8'h02,
      ST_CC = 8'h04,
      ST_CV = 8'h08,
      ST_DONE = 8'h10,
      ST_TOUT = 8'h20,
      ST_FAULT = 8'h40,
      ST_INOVP = 8'h80
   } lcs_state_type;

   // Charge timer length in seconds for each select code
   function automatic logic [TMR_W-1:0] lcs_timer_limit(input logic [1:0] sel);
      logic [TMR_W-1:0] lim;
      lim = 16'h0E10;
      case (sel)
         2'h1: lim = 16'h1C20;
         2'h2: lim = 16'h3840;
         2'h3: lim = 16'h7080;
         default: lim = 16'h0E10;
      endcase
      return lim;
   endfunction

   // Watchdog timeout in seconds for each select code
   function automatic logic [TMR_W-1:0] lcs_wdog_limit(input logic [1:0] sel);
      return 16'h0010 << sel;
   endfunction
endpackage

// File: dv/lcs_cell_model.sv
// Purpose: Analog side stand-in that turns bench voltages into comparator levels.
// Assumes: Voltages are millivolts set by the bench.
// Notes: Trip points are the fixed charger thresholds.
`timescale 1ns/10ps
module lcs_cell_model (
   input wire logic [15:0] vin_mv,
   input wire logic [15:0] vbat_mv,
   input wire logic [15:0] rail_mv,
   output logic in_ok,
   output logic in_ovp,
   output logic rail_low,
   output logic bat_ok
);
   // Comparator trip points
   assign in_ok = vin_mv > 16'h128E;
   assign in_ovp = vin_mv > 16'h1676;
   assign rail_low = (rail_mv + 16'h0064) <= vbat_mv;
   assign bat_ok = vbat_mv > 16'h0BB8;
endmodule

// File: dv/test_li_ion_charge_sequencer.sv
// Purpose: Self-checking bench for the charge sequencer.
// Assumes: Millisecond tick shortened to 4 cycles, second tick to 4 milliseconds (16 cycles).
// Notes: A single AHB-Lite master reaches the registers.
`timescale 1ns/10ps
module test_li_ion_charge_sequencer;
   import lcs_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hrdy;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [15:0] vin = 0, vbat = 0, rail = 0;
   logic flt = 0, rchg = 0, eocl = 0, in_ok, in_ovp, rail_low, bat_ok;
   logic bovp = 0, tflt = 0, ilim = 0;
   logic buck, prot, rev, pass, byp, trk, ccl, cvl, hrsp;
   logic [2:0] cc_sel, eoc_sel;
   logic [3:0] fv_sel, code;
   logic [1:0] ovm_sel, trk_sel, il_sel;
   int err_total = 0, samples_checked = 0;
   // Clock
   always #12.5 hclk = ~hclk;
   lcs_cell_model u_cell (.vin_mv(vin), .vbat_mv(vbat), .rail_mv(rail), .in_ok(in_ok),
      .in_ovp(in_ovp), .rail_low(rail_low), .bat_ok(bat_ok));
   lcs_charger #(.MS_CYCLES_P(4), .S_MS_P(4)) u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hrsp),
      .input_valid_cmp(in_ok), .input_ovp_cmp(in_ovp), .vpwr_below_vbat_cmp(rail_low),
      .batt_above_trkl_cmp(bat_ok), .batt_above_float_cmp(flt), .batt_ovp_cmp(bovp),
      .batt_above_rchg_cmp(rchg), .chg_below_eoc_cmp(eocl), .input_limit_cmp(ilim),
      .temp_fault_cmp(tflt), .charger_buck_en(buck), .input_protect_switch(prot),
      .reverse_block_switch(rev), .charge_pass_switch(pass), .bypass_switch(byp),
      .trickle_source_en(trk), .cc_loop_en(ccl), .cv_loop_en(cvl), .cc_current_sel(cc_sel),
      .float_voltage_sel(fv_sel), .overvoltage_margin_sel(ovm_sel),
      .eoc_current_sel(eoc_sel), .trickle_current_sel(trk_sel), .input_limit_sel(il_sel),
      .charger_state_code(code));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One single transfer, address phase then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hrdy !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hrdy !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(q & m, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   // Wait a bounded time for a state code, then check it
   task automatic wt(input logic [3:0] c, input int lim, output int n);
      n = 0;
      while (code !== c && n < lim) begin
         @(posedge hclk);
         n++;
      end
      #1;
      chk(32'(code), 32'(c));
   endtask
   task automatic t_regs();
      rd(OFS_CFG, 32'hFFFFFFFF, 32'h00000000);
      chk(32'(hrsp), 32'h0);
      wr(OFS_CFG, 32'h0000A755);
      cyc(2);
      chk(32'({il_sel, trk_sel, eoc_sel, ovm_sel, fv_sel, cc_sel}), 32'hA755);
      rd(OFS_CFG, 32'hFFFFFFFF, 32'h0000A755);
      rd(8'h20, 32'hFFFFFFFF, 32'h00000000);
      $display("regs done");
   endtask
   task automatic t_path();
      vbat <= 16'h0E10;
      rail <= 16'h0D7A;
      wr(OFS_CTRL, 32'h00000004);
      cyc(2);
      chk(32'({byp, pass}), 32'h3);
      rail <= 16'h0DDE;
      cyc(3);
      chk(32'(byp), 32'h0);
      rail <= 16'h0D7A;
      wr(OFS_CTRL, 32'h0000000C);
      cyc(2);
      chk(32'({byp, pass}), 32'h0);
      wr(OFS_CTRL, 32'h00000000);
      cyc(2);
      chk(32'({byp, pass}), 32'h1);
      $display("path done");
   endtask
   task automatic t_ovp();
      vin <= 16'h1770;
      cyc(3);
      chk(32'({prot, buck, rev, code}), 32'(CODE_INOVP));
      rd(OFS_EVENT, 32'h2, 32'h2);
      vin <= 16'h0000;
      wr(OFS_EVENT, 32'h000001FF);
      $display("ovp done");
   endtask
   task automatic t_chg();
      int n;
      vbat <= 16'h09C4;
      vin <= 16'h1388;
      wt(CODE_TRKL, 20, n);
      chk(32'({trk, rev, buck}), 32'h7);
      rd(OFS_EVENT, 32'h1, 32'h1);
      vbat <= 16'h0DAC;
      cyc(128);
      chk(32'(code), 32'(CODE_TRKL));
      wt(CODE_CC, 40, n);
      chk(32'({trk, ccl}), 32'h1);
      rd(OFS_EVENT, 32'h4, 32'h4);
      flt <= 1'b1;
      wt(CODE_CV, 10, n);
      chk(32'({ccl, cvl}), 32'h3);
      rchg <= 1'b1;
      eocl <= 1'b1;
      wt(CODE_DONE, 20, n);
      chk(32'(n >= 4), 32'h1);
      rd(OFS_EVENT, 32'h20, 32'h20);
      $display("charge done");
   endtask
   task automatic t_tout();
      int n;
      vin <= 16'h0000;
      flt <= 1'b0;
      rchg <= 1'b0;
      eocl <= 1'b0;
      vbat <= 16'h09C4;
      wr(OFS_CTRL, 32'h00000001);
      vin <= 16'h1388;
      // Long enough for the trickle filter to fall again
      cyc(150);
      chk(32'(code), 32'(CODE_IDLE));
      wr(OFS_CTRL, 32'h00000000);
      wt(CODE_TRKL, 10, n);
      wt(CODE_TOUT, 15000, n);
      chk(32'(n > 14300), 32'h1);
      $display("timeout done");
   endtask
   // Forced trickle, faults, input limit and watchdog
   task automatic t_flt();
      int n;
      vbat <= 16'h0DAC;
      wr(OFS_EVENT, 32'h000001FF);
      wr(OFS_CTRL, 32'h00000003);
      cyc(140);
      wr(OFS_CTRL, 32'h00000002);
      cyc(4);
      chk(32'({trk, code}), 32'h18);
      flt <= 1'b1;
      wt(CODE_DONE, 4, n);
      rd(OFS_EVENT, 32'hA4, 32'h24);
      flt <= 1'b0;
      wr(OFS_CTRL, 32'h00000001);
      wr(OFS_CTRL, 32'h00000000);
      wt(CODE_CC, 10, n);
      ilim <= 1'b1;
      tflt <= 1'b1;
      wt(CODE_FAULT, 4, n);
      chk(32'({trk, ccl}), 32'h0);
      rd(OFS_EVENT, 32'h50, 32'h50);
      ilim <= 1'b0;
      tflt <= 1'b0;
      bovp <= 1'b1;
      cyc(2);
      chk(32'({buck, rev, prot}), 32'h1);
      rd(OFS_EVENT, 32'h8, 32'h8);
      bovp <= 1'b0;
      wr(OFS_CTRL, 32'h00000011);
      cyc(300);
      rd(OFS_STATUS, 32'h10F, 32'h100);
      wr(OFS_CTRL, 32'h00000010);
      cyc(4);
      chk(32'(code), 32'(CODE_IDLE));
      wr(OFS_KICK, 32'h00000000);
      wt(CODE_CC, 10, n);
      rd(OFS_EVENT, 32'h100, 32'h100);
      $display("fault done");
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #1000000;
      err_total++;
      test_done();
   end
   // Reset, then the scenarios
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_path();
      t_ovp();
      t_chg();
      t_tout();
      t_flt();
      test_done();
   end
endmodule
